// [verilog/rhpc_port_flags.sv]
// Root hub port change flags with Wishbone register access and interrupt.
//
// Behaviour
// [RULE1] Software writes reserved status bits with their reset value, zero.
// [RULE2] Reset change flag, bit 20, sets when the 10 ms port reset ends.
// [RULE3] Writing one clears a change flag; writing zero leaves it alone.
// [RULE4] Overcurrent change flag, bit 19, is meaningful only with per-port reporting.
// [RULE5] Overcurrent change flag sets whenever the overcurrent indicator changes; here it sets only while per-port reporting is on.
// [RULE6] Suspend change flag, bit 18, sets after resume pulse, EOP and resync.
// [RULE7] Suspend change flag clears whenever the reset change flag becomes set.
// [RULE8] Enable change flag, bit 17, sets when hardware clears port enable.
// [RULE9] Software changes to port enable never set the enable change flag.
// [RULE10] Bits 31 to 21 are reserved and read as zero.
// [RULE11] All change flags read zero after reset until a port event.
//
// Implementation choice: register access over Wishbone.
`timescale 1ns/1ps
`include "rhpc_defs.svh"
module rhpc_port_flags #(
	parameter int RESET_CYC = `RHPC_MS_CYCLES(`RHPC_RESET_MS),
	parameter int RESUME_CYC = `RHPC_MS_CYCLES(`RHPC_RESUME_MS),
	parameter int RESYNC_CYC = `RHPC_MS_CYCLES(`RHPC_RESYNC_MS)
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic overcurrent_pin_i,
	input wire logic hw_disable_pin_i,
	input wire logic eop_done_i,
	output logic port_reset_o,
	output logic port_resume_o,
	output logic irq_o
);
	import rhpc_pkg::*;

	// --------------------------------------------------------------------
	// Synchronised pins and sequencer
	// --------------------------------------------------------------------
	logic [1:0] pins_sync;
	rhpc_state_e seq_state;
	logic reset_done;
	logic resume_done;
	logic start_reset;
	logic start_resume;

	rhpc_sync #(
		.W(2)
	) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i({overcurrent_pin_i, hw_disable_pin_i}),
		.q_o(pins_sync)
	);

	rhpc_timer #(
		.RESET_CYC(RESET_CYC),
		.RESUME_CYC(RESUME_CYC),
		.RESYNC_CYC(RESYNC_CYC)
	) u_timer (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_reset_i(start_reset),
		.start_resume_i(start_resume),
		.eop_done_i(eop_done_i),
		.state_o(seq_state),
		.reset_done_o(reset_done),
		.resume_done_o(resume_done)
	);

	// --------------------------------------------------------------------
	// Bus decode
	// --------------------------------------------------------------------
	rhpc_wb_req_s req;
	logic wr_hit;
	logic rd_go;
	logic [31:0] status_ones;
	logic [31:0] ctrl_ones;

	assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i,
		sel: wb_sel_i, dat: wb_dat_i};
	// Ack is one cycle late and drops after a cycle, so a request still held is taken again every second cycle.
	assign wr_hit = req.cyc && req.stb && req.we && !wb_ack_o;
	assign rd_go = req.cyc && req.stb && !wb_ack_o;

	function automatic logic [31:0] byte_mask(input logic [3:0] sel);
		byte_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	endfunction

	// Write-one strobes per bit; plain vectors keep every decode in the sensitivity lists.
	always_comb begin
		status_ones = 32'h0;
		ctrl_ones = 32'h0;
		if (wr_hit && req.adr == `RHPC_PORT_STATUS_OFS) begin
			status_ones = byte_mask(req.sel) & req.dat;
		end
		if (wr_hit && req.adr == `RHPC_CTRL_OFS) begin
			ctrl_ones = byte_mask(req.sel) & req.dat;
		end
	end

	// --------------------------------------------------------------------
	// Port state and change flags
	// --------------------------------------------------------------------
	logic enable_status;
	logic suspend_status;
	logic port_overcurrent_indicator;
	logic reset_change_flag;
	logic overcurrent_change_flag;
	logic suspend_change_flag;
	logic enable_change_flag;
	logic per_port_oc;
	logic [`RHPC_IRQ_W-1:0] irq_mask;
	logic next_enable_status;
	logic next_suspend_status;
	logic next_oc_indicator;
	logic next_rsc;
	logic next_occ;
	logic next_suc;
	logic next_enc;
	logic next_per_port_oc;
	logic [`RHPC_IRQ_W-1:0] next_irq_mask;
	logic hw_disable;

	assign hw_disable = pins_sync[0] && enable_status;
	assign start_reset = status_ones[`RHPC_BIT_RESET_ST] && seq_state == RHPC_IDLE;
	assign start_resume = suspend_status && !status_ones[`RHPC_BIT_SUSPEND]
		&& ctrl_ones[`RHPC_CTRL_RESUME] && seq_state == RHPC_IDLE;

	always_comb begin
		next_enable_status = enable_status;
		next_suspend_status = suspend_status;
		next_oc_indicator = pins_sync[1];
		next_per_port_oc = per_port_oc;
		next_irq_mask = irq_mask;
		// Software enable/suspend writes: these never touch the enable change flag.
		// [RULE9] software enable ignored
		if (status_ones[`RHPC_BIT_ENABLE]) begin
			next_enable_status = 1'b1;
		end
		if (status_ones[`RHPC_BIT_SUSPEND]) begin
			next_suspend_status = 1'b1;
		end
		if (ctrl_ones[`RHPC_CTRL_DISABLE]) begin
			next_enable_status = 1'b0;
		end
		if (hw_disable || reset_done == 1'b0 && seq_state == RHPC_RESET) begin
			next_enable_status = 1'b0;
		end
		if (reset_done) begin
			next_enable_status = 1'b1;
		end
		if (resume_done) begin
			next_suspend_status = 1'b0;
		end
		if (wr_hit && req.adr == `RHPC_CTRL_OFS && req.sel[0]) begin
			next_per_port_oc = req.dat[`RHPC_CTRL_PER_PORT_OC];
		end
		if (wr_hit && req.adr == `RHPC_INT_MASK_OFS && req.sel[0]) begin
			next_irq_mask = req.dat[`RHPC_IRQ_W-1:0];
		end
		// Flags: hardware set wins over a same-cycle software clear.
		// [RULE3] write one clears
		next_rsc = reset_change_flag && !status_ones[`RHPC_BIT_RSC];
		next_occ = overcurrent_change_flag && !status_ones[`RHPC_BIT_OCC];
		next_suc = suspend_change_flag && !status_ones[`RHPC_BIT_SUC];
		next_enc = enable_change_flag && !status_ones[`RHPC_BIT_ENC];
		// [RULE2] reset end sets flag
		if (reset_done) begin
			next_rsc = 1'b1;
		end
		// [RULE5] indicator change sets flag
		// [RULE4] only meaningful per port
		if (next_oc_indicator != port_overcurrent_indicator && per_port_oc) begin
			next_occ = 1'b1;
		end
		// [RULE6] resume complete sets flag
		if (resume_done) begin
			next_suc = 1'b1;
		end
		// [RULE7] reset change clears suspend
		if (reset_done) begin
			next_suc = 1'b0;
		end
		// [RULE8] hardware disable sets flag
		if (hw_disable) begin
			next_enc = 1'b1;
		end
	end

	// [RULE11] flags zero after reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			enable_status <= 1'b0;
			suspend_status <= 1'b0;
			port_overcurrent_indicator <= 1'b0;
			reset_change_flag <= 1'b0;
			overcurrent_change_flag <= 1'b0;
			suspend_change_flag <= 1'b0;
			enable_change_flag <= 1'b0;
			per_port_oc <= 1'b1;
			irq_mask <= '0;
		end else begin
			enable_status <= next_enable_status;
			suspend_status <= next_suspend_status;
			port_overcurrent_indicator <= next_oc_indicator;
			reset_change_flag <= next_rsc;
			overcurrent_change_flag <= next_occ;
			suspend_change_flag <= next_suc;
			enable_change_flag <= next_enc;
			per_port_oc <= next_per_port_oc;
			irq_mask <= next_irq_mask;
		end
	end

	// --------------------------------------------------------------------
	// Read data, acknowledge and outputs
	// --------------------------------------------------------------------
	logic [31:0] status_word;
	logic [`RHPC_IRQ_W-1:0] flags;
	logic [31:0] next_dat;

	assign flags = {reset_change_flag, overcurrent_change_flag, suspend_change_flag,
		enable_change_flag};

	// [RULE10] reserved bits read zero
	always_comb begin
		status_word = 32'h0;
		status_word[`RHPC_BIT_ENABLE] = enable_status;
		status_word[`RHPC_BIT_SUSPEND] = suspend_status;
		status_word[`RHPC_BIT_OC_IND] = port_overcurrent_indicator;
		status_word[`RHPC_BIT_RESET_ST] = seq_state == RHPC_RESET;
		status_word[`RHPC_BIT_ENC] = enable_change_flag;
		status_word[`RHPC_BIT_SUC] = suspend_change_flag;
		status_word[`RHPC_BIT_OCC] = overcurrent_change_flag;
		status_word[`RHPC_BIT_RSC] = reset_change_flag;
		case (req.adr)
		`RHPC_PORT_STATUS_OFS: next_dat = status_word;
		`RHPC_INT_STATUS_OFS: next_dat = {28'h0, flags};
		`RHPC_INT_MASK_OFS: next_dat = {28'h0, irq_mask};
		`RHPC_CTRL_OFS: next_dat = {31'h0, per_port_oc} << `RHPC_CTRL_PER_PORT_OC;
		default: next_dat = 32'h0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
			port_reset_o <= 1'b0;
			port_resume_o <= 1'b0;
			irq_o <= 1'b0;
		end else begin
			wb_ack_o <= rd_go;
			wb_dat_o <= rd_go ? next_dat : 32'h0;
			// A copy of the sequencer phase: each pulse lasts exactly its phase length.
			port_reset_o <= seq_state == RHPC_RESET;
			port_resume_o <= seq_state == RHPC_RESUME;
			irq_o <= |(next_irq_mask & {next_rsc, next_occ, next_suc, next_enc});
		end
	end

	// --------------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------------
	sequence resume_end_s;
		$past(seq_state) == RHPC_RESYNC && seq_state == RHPC_IDLE;
	endsequence

	reset_change_set_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE2]
		reset_done |=> reset_change_flag)
		else $error("reset change flag not set after port reset");
	suspend_clear_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE7]
		reset_done |=> !suspend_change_flag)
		else $error("suspend change flag not cleared by reset change");
	resume_set_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE6]
		resume_end_s |=> suspend_change_flag)
		else $error("suspend change flag not set after resume");
	enable_hw_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE8]
		hw_disable |=> enable_change_flag && !enable_status)
		else $error("hardware disable not flagged");
	enable_sw_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE9]
		!enable_change_flag && !hw_disable |=> !enable_change_flag)
		else $error("enable change flag set without hardware event");
	oc_change_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE5]
		per_port_oc && $changed(port_overcurrent_indicator) |-> overcurrent_change_flag)
		else $error("overcurrent change not flagged");
	clear_one_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE3]
		status_ones[`RHPC_BIT_RSC] && !reset_done |=> !reset_change_flag)
		else $error("reset change flag not cleared by write one");
	reserved_zero_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE10]
		wb_ack_o && $past(req.adr) == `RHPC_PORT_STATUS_OFS |-> wb_dat_o[31:21] == 11'h0)
		else $error("reserved status bits read nonzero");
	flags_reset_a: assert property (@(posedge clk_i) // [RULE11]
		$past(rst_i) |-> flags == 4'h0)
		else $error("change flags not zero after reset");
	reset_len_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE2]
		$rose(seq_state == RHPC_RESET) |-> !reset_done [*2])
		else $error("port reset ended too early");
	reset_end_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE2]
		$rose(reset_change_flag) |-> !port_reset_o)
		else $error("reset change flag set while port reset still driven");
endmodule

// [verilog/rhpc_defs.svh]
// Offsets, bit positions and timing constants of the port change flag block.
`ifndef RHPC_DEFS_SVH
`define RHPC_DEFS_SVH
`define RHPC_PORT_STATUS_OFS 8'h54
`define RHPC_INT_STATUS_OFS 8'h58
`define RHPC_INT_MASK_OFS 8'h5C
`define RHPC_CTRL_OFS 8'h60
`define RHPC_BIT_ENABLE 0
`define RHPC_BIT_SUSPEND 1
`define RHPC_BIT_OC_IND 3
`define RHPC_BIT_RESET_ST 4
`define RHPC_CTRL_DISABLE 0
`define RHPC_CTRL_RESUME 1
`define RHPC_CTRL_PER_PORT_OC 2
`define RHPC_BIT_ENC 17
`define RHPC_BIT_SUC 18
`define RHPC_BIT_OCC 19
`define RHPC_BIT_RSC 20
`define RHPC_RESET_MS 10
`define RHPC_RESUME_MS 20
`define RHPC_RESYNC_MS 3
`define RHPC_CLK_MHZ 100
`define RHPC_MS_CYCLES(ms) ((ms) * 1000 * `RHPC_CLK_MHZ)
`define RHPC_IRQ_W 4
`endif

// [verilog/rhpc_pkg.sv]
// Types shared by the port change flag block.
package rhpc_pkg;
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} rhpc_wb_req_s;

	typedef struct packed {
		logic reset_done;
		logic resume_done;
		logic oc_level;
		logic hw_disable;
	} rhpc_evt_s;

	typedef enum logic [1:0] {
		RHPC_IDLE = 2'b00,
		RHPC_RESET = 2'b01,
		RHPC_RESUME = 2'b10,
		RHPC_RESYNC = 2'b11
	} rhpc_state_e;
endpackage

// [verilog/rhpc_timer.sv]
// Millisecond phase sequencer: port reset, resume pulse and resynchronisation.
`timescale 1ns/1ps
`include "rhpc_defs.svh"
module rhpc_timer #(
	parameter int RESET_CYC = `RHPC_MS_CYCLES(`RHPC_RESET_MS),
	parameter int RESUME_CYC = `RHPC_MS_CYCLES(`RHPC_RESUME_MS),
	parameter int RESYNC_CYC = `RHPC_MS_CYCLES(`RHPC_RESYNC_MS)
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic start_reset_i,
	input wire logic start_resume_i,
	input wire logic eop_done_i,
	output rhpc_pkg::rhpc_state_e state_o,
	output logic reset_done_o,
	output logic resume_done_o
);
	import rhpc_pkg::*;

	rhpc_state_e state;
	rhpc_state_e next_state;
	logic [31:0] count;
	logic [31:0] next_count;
	logic eop_seen;
	logic next_eop_seen;
	logic next_reset_done;
	logic next_resume_done;

	assign state_o = state;

	always_comb begin
		next_state = state;
		next_count = count;
		next_eop_seen = eop_seen;
		next_reset_done = 1'b0;
		next_resume_done = 1'b0;
		case (state)
		RHPC_IDLE: begin
			next_count = 32'h0;
			if (start_reset_i) begin
				next_state = RHPC_RESET;
			end else if (start_resume_i) begin
				next_state = RHPC_RESUME;
			end
		end
		RHPC_RESET: begin
			next_count = count + 32'h1;
			if (count == 32'(RESET_CYC - 1)) begin
				next_state = RHPC_IDLE;
				next_reset_done = 1'b1;
			end
		end
		RHPC_RESUME: begin
			next_count = count + 32'h1;
			next_eop_seen = 1'b0;
			if (count >= 32'(RESUME_CYC - 1)) begin
				next_count = 32'h0;
				next_state = RHPC_RESYNC;
			end
		end
		RHPC_RESYNC: begin
			// The low-speed end-of-packet must be seen before the delay may finish.
			if (eop_done_i) begin
				next_eop_seen = 1'b1;
			end
			if (eop_seen || eop_done_i) begin
				next_count = count + 32'h1;
			end
			if (count == 32'(RESYNC_CYC - 1)) begin
				next_state = RHPC_IDLE;
				next_resume_done = 1'b1;
			end
		end
		default: begin
			next_state = RHPC_IDLE;
		end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= RHPC_IDLE;
			count <= 32'h0;
			eop_seen <= 1'b0;
			reset_done_o <= 1'b0;
			resume_done_o <= 1'b0;
		end else begin
			state <= next_state;
			count <= next_count;
			eop_seen <= next_eop_seen;
			reset_done_o <= next_reset_done;
			resume_done_o <= next_resume_done;
		end
	end
endmodule

// [verilog/rhpc_sync.sv]
// Two-flop synchroniser for asynchronous port pins.
`timescale 1ns/1ps
module rhpc_sync #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta;
	logic [W-1:0] next_meta;

	always_comb begin
		next_meta = d_i;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta <= '0;
			q_o <= '0;
		end else begin
			meta <= next_meta;
			q_o <= meta;
		end
	end
endmodule

// [verif/rhpc_usb_port_model.sv]
// Behavioural model of the downstream port and its attached device.
`timescale 1ns/1ps
module rhpc_usb_port_model #(
	parameter int EOP_DELAY = 25
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic port_resume_i,
	input wire logic oc_req_i,
	input wire logic fault_req_i,
	output logic overcurrent_pin_o,
	output logic hw_disable_pin_o,
	output logic eop_done_o
);
	logic resume_q;
	int cnt;
	// Pin levels follow the bench's requests; the design synchronises them.
	assign overcurrent_pin_o = oc_req_i;
	assign hw_disable_pin_o = fault_req_i;
	// The low-speed end of packet comes a while after the resume pulse ends.
	always @(posedge clk_i) begin
		resume_q <= port_resume_i;
		eop_done_o <= 1'b0;
		if (rst_i) begin
			cnt <= 0;
		end else if (resume_q && !port_resume_i) begin
			cnt <= EOP_DELAY;
		end else if (cnt != 0) begin
			cnt <= cnt - 1;
			if (cnt == 1) begin
				eop_done_o <= 1'b1;
			end
		end
	end
endmodule

// [verif/test_root_hub_port_change_flags.sv]
// Self-checking bench for the root hub port change flags.
`timescale 1ns/1ps
module test_root_hub_port_change_flags;
	localparam int RST_CYC = 20;
	localparam int RSM_CYC = 30;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic oc_req = 1'b0, fault_req = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat = 32'h0, wb_dat_o, r;
	logic wb_ack_o, oc_pin, fault_pin, eop_done, port_reset_o, port_resume_o, irq_o;
	logic [64:0] exp_q[$];
	logic [64:0] ent;
	int num_errors = 0, samples_checked = 0, seed = 32'h5A40E3A5, n;
	always #5 clk_i = ~clk_i;
	rhpc_port_flags #(.RESET_CYC(RST_CYC), .RESUME_CYC(RSM_CYC), .RESYNC_CYC(10)) u_dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .overcurrent_pin_i(oc_pin), .hw_disable_pin_i(fault_pin),
		.eop_done_i(eop_done), .port_reset_o(port_reset_o),
		.port_resume_o(port_resume_o), .irq_o(irq_o));
	rhpc_usb_port_model u_port (
		.clk_i(clk_i), .rst_i(rst_i), .port_resume_i(port_resume_o), .oc_req_i(oc_req),
		.fault_req_i(fault_req), .overcurrent_pin_o(oc_pin),
		.hw_disable_pin_o(fault_pin), .eop_done_o(eop_done));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d, errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic settle(input int k);
		repeat (k) @(posedge clk_i);
	endtask
	// The expectation is queued before the request; the monitor compares it.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
			input logic [31:0] m, input logic [31:0] e);
		int k;
		exp_q.push_back({~w, m, e});
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= 4'hF;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 50);
		if (wb_ack_o !== 1'b1) check("ack", wb_ack_o, 32'h1);
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 32'h0, 32'h0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(1'b0, a, 32'h0, m, e);
	endtask
	// Starts a port reset and measures how long the reset signalling lasts.
	task automatic port_reset;
		wr(8'h54, 32'h00000010);
		n = 0;
		while (port_reset_o !== 1'b1 && n < 100) begin
			@(posedge clk_i);
			n++;
		end
		n = 0;
		while (port_reset_o === 1'b1 && n < 100) begin
			@(posedge clk_i);
			n++;
		end
		check("reset length", n, RST_CYC);
		settle(3);
	endtask
	// ----------------------------------------
	// Output monitor and watchdog
	// ----------------------------------------
	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1) begin
			if (exp_q.size() == 0) begin
				check("ack without request", wb_ack_o, 32'h0);
			end else begin
				ent = exp_q.pop_front();
				if (ent[64]) check("read data", wb_dat_o & ent[63:32], ent[31:0]);
			end
		end
	end
	initial begin
		#100000;
		num_errors++;
		$display("unexpected timeout: expected end, seen hang");
		end_of_test;
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		settle(4);
		rst_i <= 1'b0;
		rd(8'h54, 32'hFFFE0008, 32'h0);
		rd(8'hF0, 32'hFFFFFFFF, 32'h0);
		check("irq", irq_o, 1'b0);
		r = $random(seed);
		wr(8'h5C, r);
		rd(8'h5C, 32'hF, r & 32'hF);
		wr(8'h5C, 32'h0);
		port_reset;
		rd(8'h54, 32'h00100001, 32'h00100001);
		check("irq masked", irq_o, 1'b0);
		wr(8'h5C, 32'hF);
		settle(2);
		check("irq", irq_o, 1'b1);
		wr(8'h54, 32'h0);
		rd(8'h54, 32'h00100000, 32'h00100000);
		wr(8'h54, 32'h00100000);
		rd(8'h54, 32'h00100000, 32'h0);
		settle(2);
		check("irq cleared", irq_o, 1'b0);
		wr(8'h54, 32'h2);
		// Resume request keeps per-port overcurrent reporting on (bit 2).
		wr(8'h60, 32'h6);
		n = 0;
		while (port_resume_o !== 1'b1 && n < 100) begin
			@(posedge clk_i);
			n++;
		end
		n = 0;
		while (port_resume_o === 1'b1 && n < 200) begin
			@(posedge clk_i);
			n++;
		end
		check("resume length", n, RSM_CYC);
		rd(8'h54, 32'h00040000, 32'h0);
		settle(60);
		rd(8'h54, 32'h00040002, 32'h00040000);
		port_reset;
		rd(8'h54, 32'h00140000, 32'h00100000);
		wr(8'h54, 32'h00100000);
		oc_req <= 1'b1;
		settle(5);
		rd(8'h54, 32'h00080008, 32'h00080008);
		wr(8'h54, 32'h00080000);
		oc_req <= 1'b0;
		settle(5);
		rd(8'h54, 32'h00080008, 32'h00080000);
		wr(8'h54, 32'h00080000);
		wr(8'h60, 32'h0);
		rd(8'h60, 32'h4, 32'h0);
		oc_req <= 1'b1;
		settle(5);
		rd(8'h54, 32'h00080000, 32'h0);
		wr(8'h60, 32'h1);
		rd(8'h54, 32'h00020001, 32'h0);
		wr(8'h54, 32'h1);
		fault_req <= 1'b1;
		settle(5);
		rd(8'h54, 32'h00020001, 32'h00020000);
		check("irq fault", irq_o, 1'b1);
		rd(8'h58, 32'hF, 32'h1);
		wr(8'h54, 32'h00020000);
		rd(8'h54, 32'h00020000, 32'h0);
		settle(5);
		end_of_test;
	end
endmodule
